// ---- vector_regs.svh ----
// Constants for the interrupt and exception sequencing block
`ifndef VECTOR_REGS_SVH
`define VECTOR_REGS_SVH
`define VT_DIVIDE 8'h00
`define VT_STEP 8'h01
`define VT_NMI 8'h02
`define VT_BREAK 8'h03
`define VT_OVERFLOW 8'h04
`define VT_BOUNDS 8'h05
`define VT_UNUSED 8'h06
`define VT_ESCAPE 8'h07
`define VT_TIMER0 8'h08
`define VT_TIMER1 8'h12
`define VT_TIMER2 8'h13
`define VT_DMA0 8'h0a
`define VT_DMA1 8'h0b
`define VT_EXT0 8'h0c
`define VT_RESERVED_TOP 8'h1f
`define FLAGS_IE_BIT 9
`define FLAGS_STEP_BIT 8
`define FLAGS_OVF_BIT 11
`define FLAGS_RESET 16'hf002
`define EXC_NONE 4'h0
`define EXC_DIVIDE 4'h1
`define EXC_BOUNDS 4'h2
`define EXC_UNUSED 4'h3
`define EXC_ESCAPE 4'h4
`define EXC_OVERFLOW 4'h5
`define EXC_BREAK 4'h6
`define EXC_SOFT 4'h7
`endif

// ---- vector_pkg.sv ----
// Types for the interrupt and exception sequencing block
package vector_pkg;
   // Instruction retire report from the execution unit
   typedef struct packed {
      logic valid;
      logic [3:0] exc;
      logic [7:0] soft_type;
      logic [15:0] cs;
      logic [15:0] ptr_cur;
      logic [15:0] ptr_next;
      logic [15:0] ptr_prefix;
      logic has_prefix;
      logic no_step;
      logic [15:0] flags;
   } retire_t;
   // Push request toward the stack / bus unit
   typedef struct packed {
      logic valid;
      logic [15:0] flags;
      logic [15:0] cs;
      logic [15:0] ptr;
      logic [9:0] table_addr;
      logic [7:0] vtype;
   } entry_t;
   typedef enum logic [4:0] {
      S_IDLE = 5'b00001,
      S_ACK = 5'b00010,
      S_PUSH = 5'b00100,
      S_DONE = 5'b01000,
      S_SPARE = 5'b10000
   } seq_state_t;
   typedef struct packed {
      seq_state_t st;
      entry_t ent;
      logic ack_req;
      logic nmi_pend;
      logic [1:0] nmi_sync;
      logic [1:0] intr_sync;
      logic nmi_last;
      logic [15:0] flags_out;
      logic reserved_type;
   } seq_s_t;
endpackage

// ---- vector_classify.sv ----
// Exception classifier: vector type and return address of a retired instruction
`timescale 1ns/1ps
`default_nettype none
`include "vector_regs.svh"
module vector_classify
   import vector_pkg::*;
(
   input wire retire_t ret,
   input wire logic enhanced_mode,
   input wire logic escape_trap_en,
   output logic take,
   output logic [7:0] vtype,
   output logic [15:0] ret_ptr
);
   // Escape traps only in compatible mode or with the trap bit set
   logic escape_ok;
   assign escape_ok = !enhanced_mode || escape_trap_en;
   // Internally generated types for exceptions
   always_comb begin
      take = ret.valid;
      ret_ptr = ret.ptr_next;
      case (ret.exc)
         `EXC_DIVIDE: vtype = `VT_DIVIDE;
         `EXC_BOUNDS: vtype = `VT_BOUNDS;
         `EXC_UNUSED: vtype = `VT_UNUSED;
         `EXC_OVERFLOW: begin
            vtype = `VT_OVERFLOW;
            take = ret.valid && ret.flags[`FLAGS_OVF_BIT];
         end
         `EXC_BREAK: vtype = `VT_BREAK;
         `EXC_SOFT: vtype = ret.soft_type;
         `EXC_ESCAPE: begin
            vtype = `VT_ESCAPE;
            take = ret.valid && escape_ok;
            ret_ptr = ret.has_prefix ? ret.ptr_prefix : ret.ptr_cur;
         end
         default: begin
            vtype = `VT_STEP;
            take = ret.valid && ret.flags[`FLAGS_STEP_BIT] && !ret.no_step;
         end
      endcase
   end
endmodule
`default_nettype wire

// ---- vector_seq.sv ----
// Interrupt and exception sequencer: picks a vector and issues the entry push
//
// Behaviour
// - Every interrupt pushes code segment, instruction pointer and status word.
// - Exception return address is the following instruction, except escape trap.
// - Escape trap returns to the escape opcode or its segment prefix.
// - Eight-bit vector type selects one of 256 table entries.
// - Table entry address is vector type times four.
// - Types 0 through 31 are reserved for predefined uses.
// - Exceptions vector internally; controller supplies internal and uncascaded types.
// - Other maskable requests deliver their type in an acknowledge sequence.
// - Non-maskable request always uses type 2 and is never masked.
// - Hardware requests sampled at instruction boundaries, after instruction traps.
// - Re-enabled service routine can be preempted by higher priority request.
// - Divide overflow raises type 0.
// - Single-step raises type 1 except after prefixes, segment loads, wait.
// - Breakpoint raises type 3, table offset 12.
// - Software interrupts carry any of the 256 types.
// - Escape traps always in compatible mode, enhanced only with trap bit.
// - Timers share one request, types 8, 18 and 19.
// - Default priorities; DMA types 10, 11, external inputs 12 to 15.
// - Interrupt-enable cleared after the old status word is saved.
// - Bounds check raises type 5, overflow trap with flag set type 4.
`timescale 1ns/1ps
`default_nettype none
`include "vector_regs.svh"
module vector_seq
   import vector_pkg::*;
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire retire_t ret,
   input wire logic enhanced_mode,
   input wire logic escape_trap_en,
   input wire logic nmi_pin,
   input wire logic intr_pin,
   input wire logic ctl_req,
   input wire logic [7:0] ctl_type,
   input wire logic ctl_cascaded,
   input wire logic ack_valid,
   input wire logic [7:0] ack_type,
   input wire logic push_done,
   output logic ack_cycle,
   output logic ctl_ack,
   output logic entry_valid,
   output logic [15:0] entry_flags,
   output logic [15:0] entry_cs,
   output logic [15:0] entry_ptr,
   output logic [9:0] entry_table_addr,
   output logic [7:0] entry_type,
   output logic [15:0] flags_out,
   output logic reserved_type,
   output logic busy
);
   seq_s_t s_reg;
   seq_s_t s_next;
   logic cl_take;
   logic [7:0] cl_type;
   logic [15:0] cl_ptr;
   logic busy_reg;
   logic ctl_ack_next;
   logic ctl_ack_reg;

   vector_classify u_classify (
      .ret(ret),
      .enhanced_mode(enhanced_mode),
      .escape_trap_en(escape_trap_en),
      .take(cl_take),
      .vtype(cl_type),
      .ret_ptr(cl_ptr)
   );

   // Table byte address of a type, shifted rather than multiplied
   function automatic logic [9:0] table_of(input logic [7:0] t);
      table_of = {t, 2'b00};
   endfunction

   // Load an entry record; status word copied unchanged, interrupt enable is dropped in flags_out instead
   function automatic entry_t make_entry(input logic [15:0] f, input logic [15:0] cs,
                                         input logic [15:0] ptr, input logic [7:0] t);
      make_entry.valid = 1'b1;
      make_entry.flags = f;
      make_entry.cs = cs;
      make_entry.ptr = ptr;
      make_entry.table_addr = table_of(t);
      make_entry.vtype = t;
   endfunction

   always_comb begin
      s_next = s_reg;
      ctl_ack_next = 1'b0;
      // Pins come from outside the clock domain
      s_next.nmi_sync = {s_reg.nmi_sync[0], nmi_pin};
      s_next.intr_sync = {s_reg.intr_sync[0], intr_pin};
      s_next.nmi_last = s_reg.nmi_sync[1];
      // Edge latched so a short pulse during a push is not lost
      if (s_reg.nmi_sync[1] && !s_reg.nmi_last) begin
         s_next.nmi_pend = 1'b1;
      end
      case (s_reg.st)
         S_IDLE: begin
            if (ret.valid) begin
               s_next.flags_out = ret.flags;
               // Instruction traps first, hardware only at this boundary
               if (cl_take) begin
                  s_next.ent = make_entry(ret.flags, ret.cs, cl_ptr, cl_type);
                  s_next.st = S_PUSH;
               end else if (s_reg.nmi_pend || (s_reg.nmi_sync[1] && !s_reg.nmi_last)) begin
                  s_next.nmi_pend = 1'b0;
                  s_next.ent = make_entry(ret.flags, ret.cs, ret.ptr_next, `VT_NMI);
                  s_next.st = S_PUSH;
               end else if (ret.flags[`FLAGS_IE_BIT] && ctl_req && !ctl_cascaded) begin
                  // Controller resolves priority among timers, DMA and inputs
                  s_next.ent = make_entry(ret.flags, ret.cs, ret.ptr_next,
                                          ctl_type);
                  ctl_ack_next = 1'b1;
                  s_next.st = S_PUSH;
               end else if (ret.flags[`FLAGS_IE_BIT]
                            && ((ctl_req && ctl_cascaded) || s_reg.intr_sync[1])) begin
                  s_next.ent = make_entry(ret.flags, ret.cs, ret.ptr_next, 8'h00);
                  s_next.ack_req = 1'b1;
                  s_next.st = S_ACK;
               end
               // Enable honoured from the retired status lets a handler be preempted
               if (s_next.st != S_IDLE) begin
                  s_next.flags_out[`FLAGS_IE_BIT] = 1'b0;
                  if (s_next.ent.vtype == `VT_STEP || cl_take) begin
                     s_next.flags_out[`FLAGS_STEP_BIT] = 1'b0;
                  end
               end
            end
         end
         S_ACK: begin
            // Requester drives the type during the acknowledge sequence
            if (ack_valid) begin
               s_next.ack_req = 1'b0;
               // The record was parked while waiting, so the push starts here
               s_next.ent.valid = 1'b1;
               s_next.ent.vtype = ack_type;
               s_next.ent.table_addr = table_of(ack_type);
               s_next.st = S_PUSH;
            end
         end
         S_PUSH: begin
            s_next.reserved_type = (s_reg.ent.vtype <= `VT_RESERVED_TOP);
            if (push_done) begin
               s_next.ent.valid = 1'b0;
               s_next.st = S_DONE;
            end
         end
         S_DONE: begin
            s_next.st = S_IDLE;
         end
         default: begin
            s_next.st = S_IDLE;
         end
      endcase
      if (s_next.st != S_PUSH) begin
         s_next.ent.valid = 1'b0;
      end
   end

   // All state registered in one place
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         s_reg <= '{st: S_IDLE, ent: '0, ack_req: 1'b0, nmi_pend: 1'b0, nmi_sync: 2'b00,
                    intr_sync: 2'b00, nmi_last: 1'b0, flags_out: `FLAGS_RESET,
                    reserved_type: 1'b0};
         ctl_ack_reg <= 1'b0;
         busy_reg <= 1'b0;
      end else begin
         s_reg <= s_next;
         ctl_ack_reg <= ctl_ack_next;
         busy_reg <= (s_next.st != S_IDLE);
      end
   end

   assign ack_cycle = s_reg.ack_req;
   assign ctl_ack = ctl_ack_reg;
   assign entry_valid = s_reg.ent.valid;
   assign entry_flags = s_reg.ent.flags;
   assign entry_cs = s_reg.ent.cs;
   assign entry_ptr = s_reg.ent.ptr;
   assign entry_table_addr = s_reg.ent.table_addr;
   assign entry_type = s_reg.ent.vtype;
   assign flags_out = s_reg.flags_out;
   assign reserved_type = s_reg.reserved_type;
   // Registered copy so the output comes straight from a flop
   assign busy = busy_reg;
endmodule
`default_nettype wire

// ---- vector_seq_asserts.sv ----
// Port-level assertions for the interrupt and exception sequencer
`timescale 1ns/1ps
`default_nettype none
`include "vector_regs.svh"
module vector_seq_asserts
   import vector_pkg::*;
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire retire_t ret,
   input wire logic enhanced_mode,
   input wire logic escape_trap_en,
   input wire logic ack_valid,
   input wire logic [7:0] ack_type,
   input wire logic ack_cycle,
   input wire logic entry_valid,
   input wire logic [15:0] entry_flags,
   input wire logic [15:0] entry_cs,
   input wire logic [15:0] entry_ptr,
   input wire logic [9:0] entry_table_addr,
   input wire logic [7:0] entry_type,
   input wire logic [15:0] flags_out,
   input wire logic reserved_type,
   input wire logic busy,
   input wire logic ctl_ack,
   input wire logic [7:0] ctl_type
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // A retire report that the sequencer accepts, with a given exception code
   sequence took(logic [3:0] c);
      ret.valid && !busy && ret.exc == c;
   endsequence
   addr_pair_a: assert property (entry_valid |-> entry_table_addr == {entry_type, 2'b00})
      else $error("table address not type times four");
   divide_type_a: assert property (took(`EXC_DIVIDE)
      |=> entry_type == 8'h00 && entry_valid)
      else $error("divide error type wrong");
   save_state_a: assert property (took(`EXC_UNUSED)
      |=> entry_flags == $past(ret.flags) && entry_cs == $past(ret.cs))
      else $error("saved state wrong");
   break_type_a: assert property (took(`EXC_BREAK) |=> entry_table_addr == 10'h00c)
      else $error("breakpoint offset wrong");
   soft_type_a: assert property (took(`EXC_SOFT)
      |=> entry_type == $past(ret.soft_type))
      else $error("software type wrong");
   return_next_a: assert property (took(`EXC_BOUNDS)
      |=> entry_ptr == $past(ret.ptr_next) && entry_type == 8'h05)
      else $error("bounds return address wrong");
   escape_ret_a: assert property (took(`EXC_ESCAPE)
      ##0 (!enhanced_mode || escape_trap_en)
      |=> entry_ptr == ($past(ret.has_prefix) ? $past(ret.ptr_prefix) : $past(ret.ptr_cur)))
      else $error("escape return address wrong");
   escape_gate_a: assert property (took(`EXC_ESCAPE)
      ##0 (enhanced_mode && !escape_trap_en) |=> !entry_valid || entry_type != 8'h07)
      else $error("escape trapped without trap bit");
   ack_type_a: assert property (ack_cycle && ack_valid
      |=> entry_valid && entry_type == $past(ack_type))
      else $error("acknowledged type not used");
   reserved_flag_a: assert property ($rose(entry_valid)
      |=> reserved_type == (entry_type <= 8'h1f))
      else $error("reserved flag wrong");
   ctl_type_a: assert property (ctl_ack |-> entry_valid && entry_type == $past(ctl_type))
      else $error("controller type not used");
   ie_clear_a: assert property ($rose(entry_valid) |=> !flags_out[`FLAGS_IE_BIT])
      else $error("enable flag not cleared");
endmodule
bind vector_seq vector_seq_asserts vector_seq_asserts_i (.ref_clk, .resetn, .ret, .enhanced_mode,
   .escape_trap_en, .ack_valid, .ack_type, .ack_cycle, .entry_valid, .entry_flags, .entry_cs,
   .entry_ptr, .entry_table_addr, .entry_type, .flags_out, .reserved_type, .busy, .ctl_ack,
   .ctl_type);
`default_nettype wire

// ---- vector_partner.sv ----
// Model of the interrupt controller, external requester and stack unit
`timescale 1ns/1ps
`default_nettype none
module vector_partner (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic on,
   input wire logic casc,
   input wire logic [7:0] ty,
   input wire logic [3:0] dly,
   input wire logic ack_cycle,
   input wire logic entry_valid,
   output logic ctl_req,
   output logic [7:0] ctl_type,
   output logic ctl_cascaded,
   output logic ack_valid,
   output logic [7:0] ack_type,
   output logic push_done
);
   logic [3:0] ack_cnt_reg;
   logic [3:0] push_cnt_reg;
   // Controller request follows the bench's chosen source and type
   assign ctl_req = on;
   assign ctl_type = ty;
   assign ctl_cascaded = casc;
   // Answers come after a stall; the idle type bus toggles so a stale value cannot match
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         ack_cnt_reg <= 4'h0;
         push_cnt_reg <= 4'h0;
         ack_valid <= 1'b0;
         ack_type <= 8'h00;
         push_done <= 1'b0;
      end else begin
         ack_cnt_reg <= ack_cycle ? ack_cnt_reg + 4'h1 : 4'h0;
         push_cnt_reg <= entry_valid ? push_cnt_reg + 4'h1 : 4'h0;
         ack_valid <= ack_cycle && ack_cnt_reg == dly;
         ack_type <= (ack_cycle && ack_cnt_reg == dly) ? ty : ~ack_type;
         push_done <= entry_valid && push_cnt_reg == dly;
      end
   end
endmodule
`default_nettype wire

// ---- vector_seq_tb.sv ----
// Self-checking bench for the interrupt and exception sequencer
`timescale 1ns/1ps
`default_nettype none
`include "vector_regs.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fail_count++; \
   $display("wrong value at %0t: entry field mismatch", $time); end end
module vector_seq_tb
   import vector_pkg::*;
;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic enhanced_mode, escape_trap_en, nmi_pin, intr_pin, on, casc;
   logic [7:0] ty;
   logic [3:0] dly;
   retire_t ret, r;
   logic ack_cycle, ctl_ack, entry_valid, reserved_type, busy;
   logic ctl_req, ctl_cascaded, ack_valid, push_done;
   logic [7:0] ctl_type, ack_type, entry_type;
   logic [15:0] entry_flags, entry_cs, entry_ptr, flags_out;
   logic [9:0] entry_table_addr;
   int fail_count = 0, checks_done = 0, seed = 71716, n;
   logic [7:0] vt [8] = '{8'h00, 8'h00, 8'h05, 8'h06, 8'h07, 8'h04, 8'h03, 8'h00};
   logic [7:0] hw [9] = '{8'h08, 8'h12, 8'h13, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f};
   always #20 ref_clk = ~ref_clk;
   vector_seq vector_seq_i (.ref_clk, .resetn, .ret, .enhanced_mode, .escape_trap_en, .nmi_pin,
      .intr_pin, .ctl_req, .ctl_type, .ctl_cascaded, .ack_valid, .ack_type, .push_done, .ack_cycle,
      .ctl_ack, .entry_valid, .entry_flags, .entry_cs, .entry_ptr, .entry_table_addr, .entry_type,
      .flags_out, .reserved_type, .busy);
   vector_partner vector_partner_i (.ref_clk, .resetn, .on, .casc, .ty, .dly, .ack_cycle,
      .entry_valid, .ctl_req, .ctl_type, .ctl_cascaded, .ack_valid, .ack_type, .push_done);
   // Exceptions use fixed codes, software interrupts their own type, hardware the given one
   function automatic logic [7:0] exp_type(input retire_t x, input logic [7:0] h);
      return x.exc == `EXC_SOFT ? x.soft_type : (x.exc == `EXC_NONE ? h : vt[x.exc[2:0]]);
   endfunction
   // Escape traps resume at the opcode or its prefix, everything else after it
   function automatic logic [15:0] exp_ptr(input retire_t x);
      return (x.exc == `EXC_ESCAPE) ? (x.has_prefix ? x.ptr_prefix : x.ptr_cur) : x.ptr_next;
   endfunction
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Retire one instruction and check the entry push, or its absence
   task automatic run(input logic [3:0] e, input logic [15:0] f, input logic tk,
      input logic [7:0] h);
      logic seen;
      logic exp_ack;
      seen = 1'b0;
      exp_ack = 1'b0;
      r.valid = 1'b1;
      r.exc = e;
      r.flags = f;
      r.soft_type = 8'($random(seed));
      r.cs = 16'($random(seed));
      r.ptr_cur = 16'($random(seed));
      r.ptr_next = 16'($random(seed));
      r.ptr_prefix = 16'($random(seed));
      // Outputs are read at the falling edge, where they have settled
      for (n = 0; n < 60 && busy !== 1'b0; n++) @(negedge ref_clk);
      if (n == 60) begin fail_count++; test_done(); end
      @(posedge ref_clk);
      ret <= r;
      @(posedge ref_clk);
      ret.valid <= 1'b0;
      for (n = 0; n < 40 && !seen; n++) begin
         @(negedge ref_clk);
         seen = (entry_valid === 1'b1);
      end
      `CHK(seen, tk)
      if (seen) begin
         // Only an uncascaded controller request is answered with the take pulse
         exp_ack = (e == `EXC_NONE) && on && !casc && f[`FLAGS_IE_BIT] && h != `VT_STEP
            && h != `VT_NMI;
         `CHK(ctl_ack, exp_ack)
         `CHK(entry_type, exp_type(r, h))
         `CHK(entry_table_addr, {exp_type(r, h), 2'b00})
         `CHK({entry_cs, entry_flags}, {r.cs, f})
         `CHK(entry_ptr, exp_ptr(r))
         @(negedge ref_clk);
         `CHK(flags_out[`FLAGS_IE_BIT], 1'b0)
         `CHK(flags_out[`FLAGS_STEP_BIT], 1'b0)
         `CHK(reserved_type, exp_type(r, h) <= `VT_RESERVED_TOP)
      end
      if (tk && !seen) test_done();
      $display("test with code %0d done", e);
   endtask
   initial begin
      {enhanced_mode, escape_trap_en, nmi_pin, intr_pin, on, casc} = 6'h00;
      ty = 8'h00;
      dly = 4'h0;
      ret = '0;
      r = '0;
      repeat (20) @(posedge ref_clk);
      resetn <= 1'b1;
      // Every exception code in compatible mode, stack unit stalling at random
      for (int i = 1; i < 8; i++) begin
         dly <= 4'($random(seed));
         run(4'(i), 16'h0a00, 1'b1, 8'h00);
      end
      // Enhanced mode traps escapes only with the trap bit; overflow trap needs the flag
      enhanced_mode <= 1'b1;
      run(`EXC_ESCAPE, 16'h0200, 1'b0, 8'h00);
      escape_trap_en <= 1'b1;
      r.has_prefix = 1'b1;
      run(`EXC_ESCAPE, 16'h0200, 1'b1, 8'h00);
      r.has_prefix = 1'b0;
      run(`EXC_OVERFLOW, 16'h0200, 1'b0, 8'h00);
      // Single step, then an instruction that suppresses it
      run(`EXC_NONE, 16'h0100, 1'b1, `VT_STEP);
      r.no_step = 1'b1;
      run(`EXC_NONE, 16'h0100, 1'b0, 8'h00);
      r.no_step = 1'b0;
      // Non-maskable edge while maskable requests are disabled
      nmi_pin <= 1'b1;
      repeat (4) @(posedge ref_clk);
      nmi_pin <= 1'b0;
      run(`EXC_NONE, 16'h0000, 1'b1, `VT_NMI);
      // Controller sources, alternating direct and acknowledge paths, then masked
      on <= 1'b1;
      foreach (hw[i]) begin
         ty <= hw[i];
         casc <= i[0];
         dly <= 4'($random(seed));
         run(`EXC_NONE, 16'h0200, 1'b1, hw[i]);
      end
      run(`EXC_NONE, 16'h0000, 1'b0, 8'h00);
      on <= 1'b0;
      // External request pin answered with a random type
      ty <= 8'($random(seed));
      intr_pin <= 1'b1;
      @(posedge ref_clk);
      run(`EXC_NONE, 16'h0200, 1'b1, ty);
      intr_pin <= 1'b0;
      test_done();
   end
endmodule
`default_nettype wire
